// ===== hdl/flash_bus_defs.vh
// constants for the flash bus host controller
// assumes inclusion by bare name from the design files
`ifndef FLASH_BUS_DEFS_VH
`define FLASH_BUS_DEFS_VH

// ---------------------------------------------------------------
// request kinds on the user port
// ---------------------------------------------------------------
`define KIND_CMD 2'h0
`define KIND_ADDR 2'h1
`define KIND_WRITE 2'h2
`define KIND_READ 2'h3

// ---------------------------------------------------------------
// commands accepted by a busy die
// ---------------------------------------------------------------
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78

// ---------------------------------------------------------------
// address cycle layout
// ---------------------------------------------------------------
`define ADDR_CYCLES 3'h5
`define COL_HI_MSB 4
`define COL12_BIT 4
`define PAGE_MSB 5
`define BLOCK_LO_LSB 6

// ---------------------------------------------------------------
// strobe timing (ns) and cycle counts at 50 ns
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define STROBE_LOW_NS 50
`define STROBE_HIGH_NS 50
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/addr_packer.v
// splits column, page and block fields into five address bytes
// assumes static inputs while the main engine walks the cycles
`timescale 1ns/1ps
`include "flash_bus_defs.vh"

module addr_packer (
    input wire [12:0] column_field_in,
    input wire [5:0] page_field_in,
    input wire [16:0] block_field_in,
    input wire [2:0] index_in,
    output reg [7:0] byte_out
);
    // ---------------------------------------------------------------
    // byte per address cycle
    // ---------------------------------------------------------------
    // column 11..8 forced low whenever column 12 is set
    wire [3:0] col_mid;
    assign col_mid = column_field_in[12] ? 4'h0 : column_field_in[11:8];

    // byte select by cycle index
    always @* begin
        case (index_in)
            // R5 column address bytes
            3'h0: byte_out = column_field_in[7:0];
            // R7 column mid cleared
            3'h1: byte_out = {3'h0, column_field_in[12], col_mid};
            // R6 row address bytes
            3'h2: byte_out = {block_field_in[7:6], page_field_in};
            3'h3: byte_out = block_field_in[15:8];
            3'h4: byte_out = {7'h00, block_field_in[16]};
            default: byte_out = 8'h00;
        endcase
    end
endmodule // addr_packer

// ===== hdl/flash_bus_host.v
// host controller driving the asynchronous multiplexed flash bus
// assumes one die per chip enable and bus pins sampled on core_clk_in
// Operation
// R1 - device stores address byte from low lines when address latch high
// R2 - device stores command byte from low lines when command latch high
// R3 - protect strap high at power-up enables block protection
// R4 - ready/busy is open-drain active low, low while busy
// R5 - five address cycles, first two carry column, second top bits low
// R6 - cycles three to five carry page and block bits
// R7 - host clears column 11..8 whenever column 12 is set
// R8 - commands and addresses use only the lower eight lines
// R9 - operation is command, then addresses, then data cycles
// R10 - pin levels select standby, command, address, data in or out
// R11 - write protect low blocks program and erase
// R12 - chip enable high with device idle means standby
// R13 - host may release chip enable while device is busy
// R14 - command taken on write strobe rise, ce low, cle high
// R15 - busy die ignores commands except status reads
// R16 - host drives upper lines zero during commands
// R17 - data and cache registers combine or split for cache use
// R18 - array programmed and read per page, erased per block
// R19 - latched address goes to row and column decoders
// R20 - device keeps a status register of operation outcome
// R21 - address taken on write strobe rise, ale high, cle low
// R22 - device drives read data on read strobe falling edge
// R23 - data written on write strobe rise with both latches low
// R24 - device lines high impedance except during data output
`timescale 1ns/1ps
`include "flash_bus_defs.vh"

module flash_bus_host #(
    parameter BUS_WIDTH = 16
) (
    input wire core_clk_in,
    input wire reset_in,
    input wire clk_en_in,
    // user request port
    input wire req_valid_in,
    output wire req_ready_out,
    input wire [1:0] req_kind_in,
    input wire [7:0] req_cmd_in,
    input wire [BUS_WIDTH-1:0] req_wdata_in,
    input wire [12:0] column_field_in,
    input wire [5:0] page_field_in,
    input wire [16:0] block_field_in,
    input wire protect_en_in,
    input wire release_ce_in,
    output reg rsp_valid_out,
    output reg [BUS_WIDTH-1:0] rsp_rdata_out,
    output reg busy_out,
    // flash pins
    output reg ce_n_out,
    output reg cle_out,
    output reg ale_out,
    output reg we_n_out,
    output reg read_strobe_n_out,
    output reg wp_n_out,
    output reg [BUS_WIDTH-1:0] io_out,
    output reg io_oe_out,
    input wire [BUS_WIDTH-1:0] io_in,
    input wire ready_busy_n_in
);
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_LOW = 3'h2;
    localparam ST_HIGH = 3'h3;
    localparam ST_DONE = 3'h4;
    // strobe widths round up to whole clocks, so a slower clock never shortens a strobe
    localparam integer LOW_CYC_I = `STROBE_LOW_CYC;
    localparam integer HIGH_CYC_I = `STROBE_HIGH_CYC;
    // limitation: counts above fifteen would wrap, so strobe times stay short
    localparam [3:0] LOW_CYC = LOW_CYC_I[3:0];
    localparam [3:0] HIGH_CYC = HIGH_CYC_I[3:0];

    reg [2:0] state_ff;
    reg [1:0] kind_ff;
    reg [2:0] addr_idx_ff;
    reg [3:0] cnt_ff;
    reg [7:0] cmd_ff;
    reg [BUS_WIDTH-1:0] wdata_ff;
    reg rb_ff;
    wire [7:0] addr_byte;
    wire is_status_cmd;
    wire accept;

    // ---------------------------------------------------------------
    // address byte generation
    // ---------------------------------------------------------------
    addr_packer u_packer (
        .column_field_in(column_field_in),
        .page_field_in(page_field_in),
        .block_field_in(block_field_in),
        .index_in(addr_idx_ff),
        .byte_out(addr_byte)
    );

    // R15 status reads pass while busy
    assign is_status_cmd = (req_cmd_in == `CMD_STATUS) || (req_cmd_in == `CMD_STATUS_ENH);
    // busy die: only status commands and any read cycle pass, all other requests are refused
    assign req_ready_out = (state_ff == ST_IDLE) && clk_en_in && !reset_in &&
        (rb_ff || (req_kind_in == `KIND_CMD && is_status_cmd) || req_kind_in == `KIND_READ);
    assign accept = req_valid_in && req_ready_out;

    // ---------------------------------------------------------------
    // bus sequencer
    // ---------------------------------------------------------------
    // one strobe per request, address kind walks all five cycles
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            // pins park in standby, write protect low until the target reports ready
            state_ff <= ST_IDLE;
            kind_ff <= `KIND_CMD;
            addr_idx_ff <= 3'h0;
            cnt_ff <= 4'h0;
            cmd_ff <= 8'h00;
            wdata_ff <= {BUS_WIDTH{1'b0}};
            rb_ff <= 1'b0;
            busy_out <= 1'b1;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= {BUS_WIDTH{1'b0}};
            ce_n_out <= 1'b1;
            cle_out <= 1'b0;
            ale_out <= 1'b0;
            we_n_out <= 1'b1;
            read_strobe_n_out <= 1'b1;
            wp_n_out <= 1'b0;
            io_out <= {BUS_WIDTH{1'b0}};
            io_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            // busy is one clock late; the refusal at the request port uses this copy
            // R4 busy sampled from open-drain line
            rb_ff <= ready_busy_n_in;
            busy_out <= !ready_busy_n_in;
            rsp_valid_out <= 1'b0;
            // wp moves only while idle and ready, never under a busy target
            // R11 protect tied to request control
            if (state_ff == ST_IDLE && rb_ff) begin
                wp_n_out <= !protect_en_in;
            end
            case (state_ff)
                ST_IDLE: begin
                    // R12 R13 release chip enable between operations
                    if (release_ce_in) begin
                        ce_n_out <= 1'b1;
                    end
                    // command and write data held here, address fields must stay put
                    if (accept) begin
                        kind_ff <= req_kind_in;
                        cmd_ff <= req_cmd_in;
                        wdata_ff <= req_wdata_in;
                        addr_idx_ff <= 3'h0;
                        state_ff <= ST_SETUP;
                    end
                end

                ST_SETUP: begin
                    // R10 latch levels select cycle type
                    ce_n_out <= 1'b0;
                    cle_out <= (kind_ff == `KIND_CMD);
                    ale_out <= (kind_ff == `KIND_ADDR);
                    // R24 host drives lines except on reads
                    io_oe_out <= (kind_ff != `KIND_READ);
                    case (kind_ff)
                        // R8 R16 upper lines zero for command
                        `KIND_CMD: io_out <= {{(BUS_WIDTH-8){1'b0}}, cmd_ff};
                        // R1 R21 address on low lines
                        `KIND_ADDR: io_out <= {{(BUS_WIDTH-8){1'b0}}, addr_byte};
                        `KIND_WRITE: io_out <= wdata_ff;
                        default: io_out <= {BUS_WIDTH{1'b0}};
                    endcase
                    cnt_ff <= LOW_CYC;
                    state_ff <= ST_LOW;
                end

                ST_LOW: begin
                    // strobe low for at least the low time
                    // trade-off: one clock per phase at 20 MHz keeps the counter narrow
                    if (kind_ff == `KIND_READ) begin
                        read_strobe_n_out <= 1'b0;
                    end else begin
                        we_n_out <= 1'b0;
                    end
                    if (cnt_ff <= 4'h1) begin
                        cnt_ff <= HIGH_CYC;
                        state_ff <= ST_HIGH;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end

                ST_HIGH: begin
                    // R2 R14 R23 rising edge latches at device
                    we_n_out <= 1'b1;
                    read_strobe_n_out <= 1'b1;
                    if (kind_ff == `KIND_READ && !read_strobe_n_out) begin
                        // R22 data sampled before the rise
                        // the strobe is still low at this edge, so the die still drives
                        rsp_rdata_out <= io_in;
                    end
                    if (cnt_ff <= 4'h1) begin
                        state_ff <= ST_DONE;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end

                ST_DONE: begin
                    // R5 R6 R9 walk remaining address cycles
                    if (kind_ff == `KIND_ADDR && addr_idx_ff < `ADDR_CYCLES - 3'h1) begin
                        addr_idx_ff <= addr_idx_ff + 3'h1;
                        state_ff <= ST_SETUP;
                    end else begin
                        // lines released so the die may drive the next read
                        cle_out <= 1'b0;
                        ale_out <= 1'b0;
                        io_oe_out <= 1'b0;
                        rsp_valid_out <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                end

                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // flash_bus_host

// ===== verification/flash_bus_host_properties.sv
// pin and handshake checks on the flash host controller
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
`include "flash_bus_defs.vh"
module flash_bus_host_properties #(
    parameter BUS_WIDTH = 16
) (
    input logic core_clk_in,
    input logic reset_in,
    input logic req_valid_in,
    input logic req_ready_out,
    input logic [1:0] req_kind_in,
    input logic rsp_valid_out,
    input logic busy_out,
    input logic ce_n_out,
    input logic cle_out,
    input logic ale_out,
    input logic we_n_out,
    input logic read_strobe_n_out,
    input logic [BUS_WIDTH-1:0] io_out,
    input logic io_oe_out
);
    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire take = req_valid_in && req_ready_out;
    a_cmd_upper_zero: assert property (cle_out && io_oe_out |-> io_out[BUS_WIDTH-1:8] == 0)
        else $error("upper lines not zero in command");
    a_latch_apart: assert property (!(cle_out && ale_out))
        else $error("both latches high");
    a_read_released: assert property (!read_strobe_n_out |-> !io_oe_out && !ce_n_out)
        else $error("host drives lines during read");
    a_we_selected: assert property (!we_n_out |-> !ce_n_out && read_strobe_n_out)
        else $error("write strobe without select");
    a_we_one_cycle: assert property ($fell(we_n_out) |=> we_n_out)
        else $error("write strobe low too long");
    a_rsp_latency: assert property (take && req_kind_in != `KIND_ADDR |-> ##5 rsp_valid_out)
        else $error("late answer");
    a_addr_latency: assert property (take && req_kind_in == `KIND_ADDR |-> ##21 rsp_valid_out)
        else $error("late address answer");
    a_busy_refuse: assert property (busy_out && req_kind_in == `KIND_WRITE |-> !req_ready_out)
        else $error("write taken while busy");
    cover property (take && req_kind_in == `KIND_ADDR);
    cover property (busy_out && req_valid_in && !req_ready_out);
    cover property (rsp_valid_out && !ce_n_out);
endmodule // flash_bus_host_properties

// ===== verification/nand_die_model.sv
// behavioural flash die seen at the host pins
// assumes the bench resolves the io lines and the pull-up
`timescale 1ns/1ps
`include "flash_bus_defs.vh"
module nand_die_model #(
    parameter [7:0] PROG_CMD = 8'h10,
    parameter BUSY_NS = 3000,
    parameter LOCK_STRAP = 1'b0
) (
    input wire ce_n_in,
    input wire cle_in,
    input wire ale_in,
    input wire we_n_in,
    input wire read_strobe_n_in,
    input wire wp_n_in,
    input wire [15:0] io_in,
    output wire [15:0] io_out,
    output wire io_oe_out,
    output wire rb_low_out
);
    reg [7:0] cmd_ff = 8'h00;
    reg [7:0] addr_ff [0:4];
    reg [2:0] cnt_ff = 3'h0;
    // one stage stands for data and cache registers in page mode
    reg [15:0] data_ff = 16'h0000;
    reg busy_ff = 1'b0;
    // strap read once at power-up, the pull-down leaves it low
    reg lock_en_ff = LOCK_STRAP;
    // latched bytes split into column and row for the decoders
    wire [12:0] col_dec = {addr_ff[1][4:0], addr_ff[0]};
    wire [16:0] row_dec = {addr_ff[4][0], addr_ff[3], addr_ff[2]};
    // status word, layout is this model's own: lock, write enabled, ready
    wire [15:0] status_word = {13'h0000, lock_en_ff, wp_n_in, !busy_ff};
    wire is_status = (cmd_ff == `CMD_STATUS) || (cmd_ff == `CMD_STATUS_ENH);
    wire [15:0] rd_word = is_status ? status_word : data_ff;
    assign rb_low_out = busy_ff;
    // drive only in output cycles, inverse otherwise
    assign io_oe_out = !ce_n_in && !cle_in && !ale_in && we_n_in && !read_strobe_n_in;
    assign io_out = io_oe_out ? rd_word : ~rd_word;
    always @(posedge we_n_in) begin
        if (!ce_n_in && read_strobe_n_in) begin
            if (cle_in && !ale_in && (!busy_ff || io_in[7:0] == `CMD_STATUS
                || io_in[7:0] == `CMD_STATUS_ENH)) begin
                cmd_ff = io_in[7:0];
                cnt_ff = 3'h0;
                // program takes the latched page as a whole
                if (io_in[7:0] == PROG_CMD && wp_n_in) begin
                    busy_ff = 1'b1;
                    busy_ff <= #BUSY_NS 1'b0;
                end
            end
            if (ale_in && !cle_in && !busy_ff && cnt_ff < 3'h5) begin
                addr_ff[cnt_ff] = io_in[7:0];
                cnt_ff = cnt_ff + 3'h1;
            end
            if (!ale_in && !cle_in && !busy_ff) data_ff = io_in;
        end
    end
endmodule // nand_die_model

// ===== verification/tb_flash_bus_host.sv
// directed bench for the flash host controller against a die model
// assumes the design header is on the include path
`timescale 1ns/1ps
`include "flash_bus_defs.vh"
module tb_flash_bus_host;
    reg core_clk_in = 0, reset_in = 1, req_valid_in = 0, protect_en_in = 0, release_ce_in = 0;
    reg clk_en_in = 1;
    reg [1:0] req_kind_in = 0;
    reg [7:0] req_cmd_in = 0;
    reg [15:0] req_wdata_in = 0;
    reg [12:0] column_field_in = 0;
    reg [5:0] page_field_in = 0;
    reg [16:0] block_field_in = 0;
    wire req_ready_out, rsp_valid_out, busy_out, ce_n_out, cle_out, ale_out, we_n_out;
    wire read_strobe_n_out, wp_n_out, io_oe_out, die_oe, rb_low;
    wire [15:0] rsp_rdata_out, io_out, die_io;
    // lines resolved from both drivers, busy line pulled up
    wire [15:0] io_in = io_oe_out ? io_out : die_io;
    wire ready_busy_n_in = !rb_low;
    integer fails = 0, samples_checked = 0;
    always #25 core_clk_in = ~core_clk_in;
    // host and die must never drive the lines together
    always @(posedge core_clk_in) if (die_oe && io_oe_out) chk(16'h0001, 16'h0000);
    flash_bus_host #(.BUS_WIDTH(16)) u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .clk_en_in(clk_en_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_kind_in(req_kind_in), .req_cmd_in(req_cmd_in), .req_wdata_in(req_wdata_in),
        .column_field_in(column_field_in), .page_field_in(page_field_in),
        .block_field_in(block_field_in), .protect_en_in(protect_en_in),
        .release_ce_in(release_ce_in), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .busy_out(busy_out), .ce_n_out(ce_n_out),
        .cle_out(cle_out), .ale_out(ale_out), .we_n_out(we_n_out),
        .read_strobe_n_out(read_strobe_n_out), .wp_n_out(wp_n_out), .io_out(io_out),
        .io_oe_out(io_oe_out), .io_in(io_in), .ready_busy_n_in(ready_busy_n_in));
    nand_die_model u_die (.ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out),
        .we_n_in(we_n_out), .read_strobe_n_in(read_strobe_n_out), .wp_n_in(wp_n_out),
        .io_in(io_in), .io_out(die_io), .io_oe_out(die_oe), .rb_low_out(rb_low));
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task chk(input [15:0] g, input [15:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("MISMATCH %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // ready is combinational and only moves on edges, so +1ns reads the edge value
    task req(input [1:0] k, input [7:0] c, input [15:0] w);
        integer i;
        begin
            req_kind_in = k;
            req_cmd_in = c;
            req_wdata_in = w;
            req_valid_in = 1;
            for (i = 0; i < 200 && req_ready_out !== 1'b1; i = i + 1) cyc(1);
            if (i == 200) chk(1'b0, 1'b1);
            cyc(1);
            req_valid_in = 0;
            for (i = 0; i < 30 && rsp_valid_out !== 1'b1; i = i + 1) cyc(1);
            if (i == 30) chk(1'b0, 1'b1);
        end
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task t_cmd_addr;
        reg [7:0] exp [0:4];
        integer i;
        begin
            req(`KIND_CMD, 8'h5a, 16'h0000);
            chk(u_die.cmd_ff, 8'h5a);
            column_field_in = 13'h1f34;
            page_field_in = 6'h2a;
            block_field_in = 17'h1_5a3c;
            exp[0] = 8'h34; exp[1] = 8'h10; exp[2] = 8'h2a; exp[3] = 8'h5a; exp[4] = 8'h01;
            req(`KIND_ADDR, 8'h00, 16'h0000);
            for (i = 0; i < 5; i = i + 1) chk(u_die.addr_ff[i], exp[i]);
            chk(u_die.cnt_ff, 3'h5);
            chk(u_die.col_dec, 13'h1034);
            chk(u_die.row_dec[15:0], 16'h5a2a);
            chk(u_die.row_dec[16], 1'b1);
            $display("test cmd_addr done");
        end
    endtask
    task t_data;
        begin
            req(`KIND_WRITE, 8'h00, 16'hc3a5);
            req(`KIND_READ, 8'h00, 16'h0000);
            chk(rsp_rdata_out, 16'hc3a5);
            $display("test data done");
        end
    endtask
    task t_busy;
        integer i;
        begin
            protect_en_in = 1;
            cyc(3);
            chk(wp_n_out, 1'b0);
            req(`KIND_CMD, 8'h10, 16'h0000);
            cyc(3);
            chk(busy_out, 1'b0);
            protect_en_in = 0;
            cyc(3);
            req(`KIND_CMD, 8'h10, 16'h0000);
            cyc(3);
            chk(busy_out, 1'b1);
            req_kind_in = `KIND_WRITE;
            req_valid_in = 1;
            cyc(1);
            chk(req_ready_out, 1'b0);
            req_valid_in = 0;
            cyc(1);
            req(`KIND_CMD, `CMD_STATUS, 16'h0000);
            chk(u_die.cmd_ff, 8'h70);
            req(`KIND_READ, 8'h00, 16'h0000);
            chk(rsp_rdata_out, 16'h0002);
            release_ce_in = 1;
            cyc(3);
            chk(ce_n_out, 1'b1);
            release_ce_in = 0;
            for (i = 0; i < 200 && busy_out !== 1'b0; i = i + 1) cyc(1);
            chk(busy_out, 1'b0);
            $display("test busy done");
        end
    endtask
    // frozen clock enable holds every pin and refuses requests
    task t_freeze;
        begin
            protect_en_in = 1;
            clk_en_in = 0;
            cyc(3);
            chk(wp_n_out, 1'b1);
            chk(req_ready_out, 1'b0);
            clk_en_in = 1;
            cyc(2);
            chk(wp_n_out, 1'b0);
            protect_en_in = 0;
            cyc(2);
            $display("test freeze done");
        end
    endtask
    initial begin
        cyc(20);
        chk({ce_n_out, cle_out, ale_out, we_n_out, read_strobe_n_out, wp_n_out, io_oe_out},
            7'h4c);
        reset_in = 0;
        t_cmd_addr;
        t_data;
        t_busy;
        t_freeze;
        results;
    end
    // watchdog well beyond the few hundred cycles of the tests
    initial begin
        #200000;
        fails = fails + 1;
        results;
    end
endmodule // tb_flash_bus_host
bind flash_bus_host flash_bus_host_properties #(.BUS_WIDTH(BUS_WIDTH)) u_props (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_kind_in(req_kind_in), .rsp_valid_out(rsp_valid_out),
    .busy_out(busy_out), .ce_n_out(ce_n_out), .cle_out(cle_out), .ale_out(ale_out),
    .we_n_out(we_n_out), .read_strobe_n_out(read_strobe_n_out), .io_out(io_out),
    .io_oe_out(io_oe_out));
